// ### inc/step_seq_defines.svh
// What this block does
// R1 - Cycle mode 0 to 2, default 2: one-pass stop, one-pass hold, continuous.
// R2 - Mode 0 stops the drive after one pass; only a new run restarts it.
// R3 - Mode 1 keeps the last step's frequency and direction after one pass.
// R4 - Mode 2 starts a new pass after each pass until a stop arrives.
// R5 - Resume mode 0: stop, fault or power loss restarts the next run at step one.
// R6 - Resume mode 1: keep interrupted step and its time; resume at that step's frequency.
// R7 - Resume mode 2: keep step time and output frequency; resume at that frequency.
// R8 - Retention off: power loss discards the state; next start begins at step one.
// R9 - Retention on: step, frequency and time survive power loss; resume per resume mode.
// R10 - Time unit picks seconds or minutes for step durations only; ramps stay seconds.
// R11 - Fifteen durations, default 10.0; step one 0.1 to 3600, others 0.0 to 3600.
// R12 - A step with zero duration is skipped straight to the following step.
// R13 - Each step has a profile of direction and ramp set, default set one forward.
// R14 - Eight profile codes: ramp set one to four, forward or reverse.
// R15 - A readable record of the executing step, 0 to 15.
// R16 - A readable record of the time spent in the executing step, 0.0 to 3600.
// R17 - Writing one to record clear zeroes both records, then the bit returns to zero.
// R18 - External start, pause and reset requests drive the step program.
// R19 - Steps run in ascending order; advance when elapsed time reaches duration.
// R20 - Elapsed time counts 0.1 unit ticks from the clock, held while paused or stopped.
`ifndef STEP_SEQ_DEFINES_SVH
`define STEP_SEQ_DEFINES_SVH

// Register byte offsets.
`define SEQ_CTRL_OFS 8'h00
`define SEQ_DUR_BASE 8'h40
`define SEQ_PROF_BASE 8'h80
`define SEQ_STAT_OFS 8'hC0
`define SEQ_ELAP_OFS 8'hC4
`define SEQ_FREQ_OFS 8'hC8

// Control register fields.
`define SEQ_CYC_LSB 0
`define SEQ_RES_LSB 2
`define SEQ_RETAIN_BIT 4
`define SEQ_UNIT_BIT 5
`define SEQ_CLEAR_BIT 8

// Reset values and limits, durations in tenths of a unit.
`define SEQ_CYC_RST 2'h2
`define SEQ_RES_RST 2'h0
`define SEQ_DUR_RST 16'h0064
`define SEQ_DUR_MAX 16'h8CA0
`define SEQ_DUR_MIN_FIRST 16'h0001
`define SEQ_MODE_MAX 2'h2

// Pin indices of the command terminals.
`define SEQ_PIN_RUN 0
`define SEQ_PIN_STOP 1
`define SEQ_PIN_FAULT 2
`define SEQ_PIN_START 3
`define SEQ_PIN_PAUSE 4
`define SEQ_PIN_RESET 5
`define SEQ_PIN_PWR 6

// Timing: one base tick is a tenth of a second.
`define SEQ_CLK_PERIOD_NS 25
`define SEQ_TICK_TIME_NS 100000000
`define SEQ_TICK_CYCLES (`SEQ_TICK_TIME_NS / `SEQ_CLK_PERIOD_NS)
`define SEQ_MIN_LAST 6'h3B

`endif

// ### inc/step_seq_pkg.sv
package step_seq_pkg;

    // Sequencer states.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_PAUSE = 2'b10,
        ST_HOLD = 2'b11
    } seq_st_t;

    // Whole state of the sequencer.
    typedef struct packed {
        seq_st_t st;
        logic [3:0] step;
        logic [15:0] elapsed;
        logic [31:0] presc;
        logic [5:0] minc;
        logic saved;
        logic use_ret;
        logic [15:0] ret_freq;
        logic [3:0] rec;
        logic [1:0] cyc;
        logic [1:0] res;
        logic retain;
        logic unit;
        logic [14:0][15:0] dur;
        logic [14:0][2:0] prof;
        logic [6:0] sync1;
        logic [6:0] sync2;
        logic [6:0] prev;
        logic dp_wr;
        logic [7:0] dp_addr;
        logic [31:0] rdata;
        logic rdy;
        logic o_run;
        logic o_rev;
        logic [1:0] o_ramp;
        logic o_paused;
    } seq_reg_t;

endpackage

// ### rtl/multi_step_speed_sequencer.sv
// Added by the designer: the AHB-Lite slave port and the register offsets.
`include "step_seq_defines.svh"

module multi_step_speed_sequencer #(
    parameter int unsigned TICK_CYCLES = `SEQ_TICK_CYCLES
) (
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic rst_i,
    // AHB-Lite slave.
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Command terminals, asynchronous to the clock.
    input wire logic run_cmd_i,
    input wire logic stop_cmd_i,
    input wire logic fault_i,
    input wire logic ext_start_i,
    input wire logic ext_pause_i,
    input wire logic ext_reset_i,
    input wire logic power_fail_i,
    // Frequency now output by the control core.
    input wire logic [15:0] out_freq_i,
    // Commands to the control core.
    output logic drive_run_o,
    output logic reverse_o,
    output logic [1:0] ramp_set_o,
    output logic [3:0] active_step_o,
    output logic use_retained_freq_o,
    output logic [15:0] retained_freq_o,
    output logic seq_paused_o
);

    localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

    // The prescaler cannot count a zero-length tick.
    if (TICK_CYCLES < 1) begin : g_bad_tick
        $error("TICK_CYCLES must be at least 1");
    end

    step_seq_pkg::seq_reg_t seq_ff;
    step_seq_pkg::seq_reg_t nxt_seq;
    logic [6:0] pins;
    logic [6:0] rise;
    logic halt;
    logic base_tick;
    logic unit_tick;
    logic dur_done;
    logic advance;
    logic pass_end;
    logic clr_req;
    logic [4:0] follow;
    logic [15:0] dur_wr;

    assign pins = {power_fail_i, ext_reset_i, ext_pause_i, ext_start_i,
                   fault_i, stop_cmd_i, run_cmd_i};
    assign rise = seq_ff.sync2 & ~seq_ff.prev;

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers.

    // Lowest step above cur with nonzero duration; bit 4 says one was found.
    function automatic logic [4:0] next_nonzero(input logic [3:0] cur,
                                                 input logic [14:0][15:0] d);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 14; i >= 0; i--) begin
            if (4'(i) > cur && d[i] != 16'h0000) begin
                r = {1'b1, 4'(i)};
            end
        end
        return r;
    endfunction

    // Register read mux; unmapped offsets read as zero.
    function automatic logic [31:0] read_word(input logic [7:0] a,
                                              input step_seq_pkg::seq_reg_t s);
        logic [31:0] r;
        r = 32'h0000_0000;
        if (a == `SEQ_CTRL_OFS) begin
            r[`SEQ_CYC_LSB +: 2] = s.cyc;
            r[`SEQ_RES_LSB +: 2] = s.res;
            r[`SEQ_RETAIN_BIT] = s.retain;
            r[`SEQ_UNIT_BIT] = s.unit;
        end else if (a == `SEQ_STAT_OFS) begin
            r[7:0] = {s.saved, s.st == step_seq_pkg::ST_HOLD,
                      s.st == step_seq_pkg::ST_PAUSE, s.o_run, s.rec};
        end else if (a == `SEQ_ELAP_OFS) begin
            r[15:0] = s.elapsed;
        end else if (a == `SEQ_FREQ_OFS) begin
            r[15:0] = s.ret_freq;
        end
        for (int i = 0; i < 15; i++) begin
            if (a == 8'(`SEQ_DUR_BASE + 4 * i)) begin
                r[15:0] = s.dur[i];
            end
            if (a == 8'(`SEQ_PROF_BASE + 4 * i)) begin
                r[2:0] = s.prof[i];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    // All state advances from this one process.
    always_comb begin
        nxt_seq = seq_ff;
        dur_wr = 16'h0000;
        clr_req = 1'b0;
        base_tick = 1'b0;
        unit_tick = 1'b0;
        // Terminals pass two flops; edges are taken after the second.
        nxt_seq.sync1 = pins;
        nxt_seq.sync2 = seq_ff.sync1;
        nxt_seq.prev = seq_ff.sync2;
        halt = seq_ff.sync2[`SEQ_PIN_STOP] | seq_ff.sync2[`SEQ_PIN_FAULT]
             | seq_ff.sync2[`SEQ_PIN_PWR];

        // Address phase: read data is fetched now so it stands in the data phase.
        nxt_seq.rdy = 1'b1;
        nxt_seq.dp_wr = 1'b0;
        nxt_seq.rdata = 32'h0000_0000;
        if (hsel_i && htrans_i[1] && hready_i && haddr_i[31:8] == 24'h00_0000) begin
            nxt_seq.dp_addr = haddr_i[7:0];
            nxt_seq.dp_wr = hwrite_i;
            if (!hwrite_i) begin
                nxt_seq.rdata = read_word(haddr_i[7:0], seq_ff);
            end
        end

        // Data phase writes; out-of-range mode codes are ignored.
        if (seq_ff.dp_wr) begin
            if (seq_ff.dp_addr == `SEQ_CTRL_OFS) begin
                if (hwdata_i[`SEQ_CYC_LSB +: 2] <= `SEQ_MODE_MAX) begin
                    nxt_seq.cyc = hwdata_i[`SEQ_CYC_LSB +: 2]; // see R1
                end
                if (hwdata_i[`SEQ_RES_LSB +: 2] <= `SEQ_MODE_MAX) begin
                    nxt_seq.res = hwdata_i[`SEQ_RES_LSB +: 2];
                end
                nxt_seq.retain = hwdata_i[`SEQ_RETAIN_BIT];
                nxt_seq.unit = hwdata_i[`SEQ_UNIT_BIT]; // see R10
                clr_req = hwdata_i[`SEQ_CLEAR_BIT]; // see R17
            end
            for (int i = 0; i < 15; i++) begin
                if (seq_ff.dp_addr == 8'(`SEQ_DUR_BASE + 4 * i)) begin
                    // Clamp into range; step one may never be zero.
                    dur_wr = (hwdata_i[15:0] > `SEQ_DUR_MAX) ? `SEQ_DUR_MAX : hwdata_i[15:0];
                    if (i == 0 && dur_wr == 16'h0000) begin
                        dur_wr = `SEQ_DUR_MIN_FIRST; // see R11
                    end
                    nxt_seq.dur[i] = dur_wr;
                end
                if (seq_ff.dp_addr == 8'(`SEQ_PROF_BASE + 4 * i)) begin
                    nxt_seq.prof[i] = hwdata_i[2:0]; // see R13
                end
            end
        end

        // Tick chain; the minute divider sits only in front of step time.
        if (seq_ff.st == step_seq_pkg::ST_RUN) begin
            if (seq_ff.presc == TICK_LAST) begin
                nxt_seq.presc = 32'h0000_0000;
                base_tick = 1'b1; // see R20
            end else begin
                nxt_seq.presc = seq_ff.presc + 32'h0000_0001;
            end
            if (base_tick) begin
                if (!seq_ff.unit) begin
                    unit_tick = 1'b1;
                end else if (seq_ff.minc == `SEQ_MIN_LAST) begin
                    nxt_seq.minc = 6'h00;
                    unit_tick = 1'b1; // see R10
                end else begin
                    nxt_seq.minc = seq_ff.minc + 6'h01;
                end
            end
        end
        follow = next_nonzero(seq_ff.step, seq_ff.dur); // see R12
        dur_done = (seq_ff.elapsed + 16'h0001) >= seq_ff.dur[seq_ff.step];
        advance = unit_tick && dur_done && follow[4]; // see R19
        pass_end = unit_tick && dur_done && !follow[4];

        // Command priority: halt, reset, pause, start, then timing.
        if (halt) begin
            if (seq_ff.st != step_seq_pkg::ST_IDLE) begin
                nxt_seq.st = step_seq_pkg::ST_IDLE;
                if (seq_ff.res == 2'h0) begin
                    nxt_seq.saved = 1'b0; // see R5
                    nxt_seq.step = 4'h0;
                    nxt_seq.elapsed = 16'h0000;
                end else begin
                    nxt_seq.saved = 1'b1; // see R6
                end
                if (seq_ff.res == 2'h2) begin
                    nxt_seq.ret_freq = out_freq_i; // see R7
                end
                nxt_seq.use_ret = 1'b0;
            end
            // Without retention a power loss forgets the position.
            if (rise[`SEQ_PIN_PWR] && !seq_ff.retain) begin
                nxt_seq.saved = 1'b0; // see R8
                nxt_seq.step = 4'h0;
                nxt_seq.elapsed = 16'h0000;
                nxt_seq.ret_freq = 16'h0000;
                nxt_seq.presc = 32'h0000_0000;
                nxt_seq.minc = 6'h00;
            end
        end else if (rise[`SEQ_PIN_RESET]) begin
            // External reset rewinds the program; a running drive restarts at step one.
            nxt_seq.saved = 1'b0; // see R18
            nxt_seq.use_ret = 1'b0;
            nxt_seq.step = 4'h0;
            nxt_seq.elapsed = 16'h0000;
            nxt_seq.presc = 32'h0000_0000;
            nxt_seq.minc = 6'h00;
            if (seq_ff.st != step_seq_pkg::ST_IDLE) begin
                nxt_seq.st = step_seq_pkg::ST_RUN;
            end
        end else if (seq_ff.st == step_seq_pkg::ST_RUN && seq_ff.sync2[`SEQ_PIN_PAUSE]) begin
            nxt_seq.st = step_seq_pkg::ST_PAUSE; // see R18
        end else if (seq_ff.st == step_seq_pkg::ST_PAUSE && !seq_ff.sync2[`SEQ_PIN_PAUSE]) begin
            nxt_seq.st = step_seq_pkg::ST_RUN;
        end else if (seq_ff.st == step_seq_pkg::ST_IDLE
                     && (rise[`SEQ_PIN_RUN] || rise[`SEQ_PIN_START])) begin
            nxt_seq.st = step_seq_pkg::ST_RUN;
            if (seq_ff.saved) begin
                // Resume where it stopped; mode 2 also reuses the kept frequency.
                nxt_seq.use_ret = seq_ff.res == 2'h2; // see R9
            end else begin
                nxt_seq.step = 4'h0;
                nxt_seq.elapsed = 16'h0000;
                nxt_seq.presc = 32'h0000_0000;
                nxt_seq.minc = 6'h00;
            end
            nxt_seq.saved = 1'b0;
        end else if (advance) begin
            nxt_seq.step = follow[3:0]; // see R19
            nxt_seq.elapsed = 16'h0000;
            nxt_seq.use_ret = 1'b0;
        end else if (pass_end) begin
            nxt_seq.use_ret = 1'b0;
            unique case (seq_ff.cyc)
                2'h0: begin
                    nxt_seq.st = step_seq_pkg::ST_IDLE; // see R2
                    nxt_seq.step = 4'h0;
                    nxt_seq.elapsed = 16'h0000;
                end
                2'h1: begin
                    nxt_seq.st = step_seq_pkg::ST_HOLD; // see R3
                end
                2'h2: begin
                    nxt_seq.step = 4'h0; // see R4
                    nxt_seq.elapsed = 16'h0000;
                end
                default: begin
                    nxt_seq.st = step_seq_pkg::ST_IDLE;
                end
            endcase
        end else if (unit_tick) begin
            nxt_seq.elapsed = seq_ff.elapsed + 16'h0001; // see R16
        end

        // Records; a clear in an idle machine also drops the kept position.
        if (clr_req) begin
            nxt_seq.rec = 4'h0; // see R17
            nxt_seq.elapsed = 16'h0000;
            if (nxt_seq.st == step_seq_pkg::ST_IDLE) begin
                nxt_seq.step = 4'h0;
                nxt_seq.saved = 1'b0;
            end
        end else if (nxt_seq.st != step_seq_pkg::ST_IDLE || nxt_seq.saved) begin
            nxt_seq.rec = nxt_seq.step + 4'h1; // see R15
        end else begin
            nxt_seq.rec = 4'h0;
        end

        // Outputs follow the next state so they leave flops in step with it.
        nxt_seq.o_run = nxt_seq.st != step_seq_pkg::ST_IDLE;
        nxt_seq.o_rev = nxt_seq.prof[nxt_seq.step][2]; // see R14
        nxt_seq.o_ramp = nxt_seq.prof[nxt_seq.step][1:0];
        nxt_seq.o_paused = nxt_seq.st == step_seq_pkg::ST_PAUSE;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register.

    // Power-on reset loads defaults; retention covers only the power-fail input.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            seq_ff <= '0;
            seq_ff.cyc <= `SEQ_CYC_RST;
            seq_ff.res <= `SEQ_RES_RST;
            seq_ff.rdy <= 1'b1;
            for (int i = 0; i < 15; i++) begin
                seq_ff.dur[i] <= `SEQ_DUR_RST;
            end
        end else begin
            seq_ff <= nxt_seq;
        end
    end

    assign hrdata_o = seq_ff.rdata;
    assign hreadyout_o = seq_ff.rdy;
    assign hresp_o = seq_ff.o_paused & 1'b0;
    assign drive_run_o = seq_ff.o_run;
    assign reverse_o = seq_ff.o_rev;
    assign ramp_set_o = seq_ff.o_ramp;
    assign active_step_o = seq_ff.rec;
    assign use_retained_freq_o = seq_ff.use_ret;
    assign retained_freq_o = seq_ff.ret_freq;
    assign seq_paused_o = seq_ff.o_paused;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence halt_in_run;
        (seq_ff.st == step_seq_pkg::ST_RUN) && halt && !rise[`SEQ_PIN_PWR] && !clr_req;
    endsequence

    sequence pass_done(logic [1:0] m);
        pass_end && !halt && !rise[`SEQ_PIN_RESET] && seq_ff.cyc == m && !clr_req
        && !seq_ff.sync2[`SEQ_PIN_PAUSE];
    endsequence

    mode_in_range_a: assert property (seq_ff.cyc <= 2'h2 && seq_ff.res <= 2'h2) // see R1
        else $error("mode setting out of range");

    single_stop_a: assert property (pass_done(2'h0) |=> // see R2
        !drive_run_o && seq_ff.st == step_seq_pkg::ST_IDLE && active_step_o == 4'h0)
        else $error("mode 0 did not stop after a pass");

    hold_last_a: assert property (pass_done(2'h1) |=> // see R3
        drive_run_o && seq_ff.st == step_seq_pkg::ST_HOLD && $stable(seq_ff.step))
        else $error("mode 1 did not hold the last step");

    wrap_pass_a: assert property (pass_done(2'h2) |=> // see R4
        drive_run_o && seq_ff.step == 4'h0 && seq_ff.elapsed == 16'h0000)
        else $error("mode 2 did not start a new pass");

    restart_first_a: assert property (halt_in_run ##0 (seq_ff.res == 2'h0) |=> // see R5
        !seq_ff.saved && seq_ff.step == 4'h0 && !drive_run_o)
        else $error("resume mode 0 kept the position");

    keep_step_a: assert property (halt_in_run ##0 (seq_ff.res == 2'h1) |=> // see R6
        seq_ff.saved && seq_ff.step == $past(seq_ff.step))
        else $error("resume mode 1 lost the step");

    keep_freq_a: assert property (halt_in_run ##0 (seq_ff.res == 2'h2) |=> // see R7
        seq_ff.ret_freq == $past(out_freq_i) ##1 seq_ff.saved)
        else $error("resume mode 2 lost the frequency");

    power_forget_a: assert property (halt && rise[`SEQ_PIN_PWR] && !seq_ff.retain |=> // see R8
        !seq_ff.saved && seq_ff.step == 4'h0 && seq_ff.elapsed == 16'h0000)
        else $error("power loss kept state without retention");

    no_zero_step_a: assert property (seq_ff.st == step_seq_pkg::ST_RUN |-> // see R12
        seq_ff.dur[seq_ff.step] != 16'h0000 || $past(seq_ff.dp_wr))
        else $error("running a zero-length step");

    clear_records_a: assert property (clr_req |=> // see R17
        active_step_o == 4'h0 && seq_ff.elapsed == 16'h0000)
        else $error("record clear did not zero the records");

    hold_when_idle_a: assert property (seq_ff.st != step_seq_pkg::ST_RUN |=> // see R20
        seq_ff.elapsed == $past(seq_ff.elapsed) || $past(clr_req)
        || $past(rise[`SEQ_PIN_RESET]) || $past(halt) || $past(rise[`SEQ_PIN_RUN])
        || $past(rise[`SEQ_PIN_START]))
        else $error("elapsed time moved while not running");

endmodule

// ### test/drive_core_model.sv
module drive_core_model (
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Commands from the sequencer.
    input wire logic drive_run_i,
    input wire logic [1:0] ramp_set_i,
    input wire logic use_retained_freq_i,
    input wire logic [15:0] retained_freq_i,
    // Frequency now output.
    output logic [15:0] out_freq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] FREQ_CAP = 16'h0020;
    logic use_q;
    logic [15:0] up;

    // A low cap makes the frequency at a late stop exact, so a kept value can be checked.
    assign up = out_freq_o + {14'h0, ramp_set_i} + 16'h0001;

    // Ramp up while running, coast down when stopped, jump to a kept value on resume.
    always_ff @(posedge core_clk_i) begin
        use_q <= use_retained_freq_i;
        if (rst_i) begin
            out_freq_o <= 16'h0000;
        end else if (use_retained_freq_i && !use_q) begin
            out_freq_o <= retained_freq_i;
        end else if (drive_run_i && !use_retained_freq_i) begin
            out_freq_o <= (up > FREQ_CAP) ? FREQ_CAP : up;
        end else if (!drive_run_i && out_freq_o != 16'h0000) begin
            out_freq_o <= out_freq_o - 16'h0001;
        end
    end
endmodule

// ### test/tb_multi_step_speed_sequencer.sv
`include "step_seq_defines.svh"
module tb_multi_step_speed_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TC = 4;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [6:0] pins = 7'h00;
    logic [31:0] hrdata, rd, e;
    logic [31:0] seed = 32'h00000031;
    logic hready, hresp, run, rev, use_ret, paused;
    logic [1:0] ramp;
    logic [3:0] step;
    logic [15:0] freq, ret_freq;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;
    int n;

    multi_step_speed_sequencer #(.TICK_CYCLES(TC)) u_multi_step_speed_sequencer (
        .core_clk_i(clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .run_cmd_i(pins[0]), .stop_cmd_i(pins[1]), .fault_i(pins[2]), .ext_start_i(pins[3]),
        .ext_pause_i(pins[4]), .ext_reset_i(pins[5]), .power_fail_i(pins[6]),
        .out_freq_i(freq), .drive_run_o(run), .reverse_o(rev), .ramp_set_o(ramp),
        .active_step_o(step), .use_retained_freq_o(use_ret), .retained_freq_o(ret_freq),
        .seq_paused_o(paused));

    drive_core_model u_drive_core_model (
        .core_clk_i(clk), .rst_i(rst), .drive_run_i(run), .ramp_set_i(ramp),
        .use_retained_freq_i(use_ret), .retained_freq_i(ret_freq), .out_freq_o(freq));

    ////////////////////////////////////////////////////////////////////////////////////////
    // Free-running clock; the cycle counter cuts a hung run short.
    initial begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (n_fail == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [31:0] cfg(int c, int r, int t, int u);
        return {26'h0, 1'(u), 1'(t), 2'(r), 2'(c)};
    endfunction

    // One single transfer; outputs read right after an edge still hold the pre-edge value.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        bus(1'b0, a, 32'h0);
        chk(rd, x);
        chk(hresp, 32'h0);
    endtask

    task automatic pin(input int i, input logic v);
        pins[i] <= v;
        repeat (5) @(posedge clk);
    endtask

    // Counts edges until the step record moves, giving up quietly at the limit.
    task automatic wchg(input int lim);
        logic [3:0] s0;
        s0 = step;
        n = 0;
        while (step === s0 && n < lim) begin
            @(posedge clk);
            n++;
        end
    endtask

    // Halt by one cause, release it, then start from the terminal and see where it resumes.
    task automatic stopgo(input int cause, input int x);
        pin(cause, 1'b1);
        chk(run, 0);
        pin(cause, 1'b0);
        pins[3] <= 1'b1;
        wchg(20);
        pins[3] <= 1'b0;
        chk(step, x);
        chk(run, 1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////
    // Random program, one zero-length step, then a whole pass in the given cycle mode.
    task automatic pass(input int m);
        int q[$];
        int d[15];
        int p[15];
        for (int k = 0; k < 15; k++) begin
            d[k] = (k == 2) ? 0 : 1 + int'(xs() % 3);
            p[k] = int'(xs() % 8);
            wr(`SEQ_DUR_BASE + 8'(4 * k), 32'(d[k]));
            wr(`SEQ_PROF_BASE + 8'(4 * k), 32'(p[k]));
            if (d[k] != 0) q.push_back(k + 1);
        end
        wr(`SEQ_CTRL_OFS, cfg(m, 0, 0, 0));
        pins[0] <= 1'b1;
        foreach (q[j]) begin
            wchg(80);
            chk(step, q[j]);
            chk(rev, p[q[j] - 1] >> 2);
            chk(ramp, p[q[j] - 1] & 3);
            if (j > 0) chk(n >= 4 * d[q[j - 1] - 1] - 4 && n <= 4 * d[q[j - 1] - 1] + 4, 1);
        end
        pins[0] <= 1'b0;
        if (m == 2) begin
            wchg(80);
            chk(step, q[0]);
        end else begin
            repeat (30) @(posedge clk);
            chk(run, m);
            if (m == 1) chk({step, rev}, {4'hF, 1'(p[14] >> 2)});
        end
        pin(1, 1'b1);
        pin(1, 1'b0);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdc(`SEQ_CTRL_OFS, 32'h00000002);
        for (int k = 0; k < 15; k++) rdc(`SEQ_DUR_BASE + 8'(4 * k), 32'h00000064);
        rdc(`SEQ_PROF_BASE, 32'h00000000);
        rdc(`SEQ_STAT_OFS, 32'h00000000);
        rdc(8'h30, 32'h00000000);
        wr(`SEQ_CTRL_OFS, 32'h00000003);
        rdc(`SEQ_CTRL_OFS, 32'h00000002);
        wr(`SEQ_DUR_BASE, 32'h00000000);
        rdc(`SEQ_DUR_BASE, 32'h00000001);
        wr(`SEQ_DUR_BASE + 8'h04, 32'h0000FFFF);
        rdc(`SEQ_DUR_BASE + 8'h04, 32'h00008CA0);
        for (int m = 0; m < 3; m++) pass(m);
        // Long steps leave room to stop and resume inside step two.
        for (int k = 0; k < 15; k++) wr(`SEQ_DUR_BASE + 8'(4 * k), 32'h00000028);
        wr(`SEQ_CTRL_OFS, cfg(2, 1, 0, 0));
        pins[0] <= 1'b1;
        wchg(40);
        pins[0] <= 1'b0;
        wchg(200);
        repeat (10) @(posedge clk);
        stopgo(1, 2);
        wr(`SEQ_CTRL_OFS, cfg(2, 2, 0, 0));
        repeat (40) @(posedge clk);
        stopgo(2, 2);
        chk({use_ret, ret_freq}, 32'h00010020);
        wr(`SEQ_CTRL_OFS, cfg(2, 0, 0, 0));
        stopgo(1, 1);
        wchg(200);
        pin(5, 1'b1);
        chk(step, 1);
        pin(5, 1'b0);
        pin(4, 1'b1);
        chk(paused, 1);
        bus(1'b0, `SEQ_ELAP_OFS, 32'h0);
        e = rd;
        repeat (40) @(posedge clk);
        rdc(`SEQ_ELAP_OFS, e);
        pin(4, 1'b0);
        wr(`SEQ_CTRL_OFS, cfg(2, 1, 1, 0));
        wchg(200);
        stopgo(6, 2);
        wr(`SEQ_CTRL_OFS, cfg(2, 1, 0, 0));
        stopgo(6, 1);
        pin(1, 1'b1);
        wr(`SEQ_CTRL_OFS, cfg(2, 1, 0, 0) | 32'h00000100);
        rdc(`SEQ_STAT_OFS, 32'h00000000);
        rdc(`SEQ_ELAP_OFS, 32'h00000000);
        rdc(`SEQ_CTRL_OFS, cfg(2, 1, 0, 0));
        pin(1, 1'b0);
        // Minute unit: one tenth lasts sixty base ticks.
        wr(`SEQ_CTRL_OFS, cfg(2, 0, 0, 1));
        wr(`SEQ_DUR_BASE, 32'h00000001);
        pins[0] <= 1'b1;
        wchg(40);
        pins[0] <= 1'b0;
        wchg(400);
        chk(n >= 60 * TC - 4 && n <= 60 * TC + 4, 1);
        tally_and_finish();
    end
endmodule
